// ==== core/ddpi_consts.svh ====
// Constants of the DDR2 pin interface: field positions and reset values
`ifndef DDPI_CONSTS_SVH
`define DDPI_CONSTS_SVH

// ---------------------------------------------------------------
// Mode register selects on the bank address
// ---------------------------------------------------------------
`define DDPI_BA_MR 3'h0
`define DDPI_BA_EMR1 3'h1
`define DDPI_BA_EMR2 3'h2
`define DDPI_BA_EMR3 3'h3

// ---------------------------------------------------------------
// Field positions and codes
// ---------------------------------------------------------------
`define DDPI_AP_BIT 10
`define DDPI_BL_MSB 2
`define DDPI_BL8 3'h3
`define DDPI_EMR1_RTT_LO 2
`define DDPI_EMR1_RTT_HI 6
`define DDPI_EMR1_DQSN_DIS 10
`define DDPI_EMR1_RDQS_EN 11

// ---------------------------------------------------------------
// Reset values and sizes
// ---------------------------------------------------------------
`define DDPI_RST_MODE 14'h0000
`define DDPI_BEATS_BL4 4'h4
`define DDPI_BEATS_BL8 4'h8
`define DDPI_FIFO_DEPTH 8
`define DDPI_MEM_WORDS 32

`endif

// ==== core/ddpi_pkg.sv ====
// Types of the DDR2 pin interface
package ddpi_pkg;

  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_NOP = 3'h7
  } ddpi_cmd_e;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_PPD    = 2'h1,
    PWR_APD    = 2'h2,
    PWR_SREF   = 2'h3
  } ddpi_pwr_e;

endpackage

// ==== core/ddpi_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ddpi_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== core/ddpi_fifo.sv ====
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ddpi_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // Explicit wrap keeps non power-of-two depths legal
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == LAST) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == LAST) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ==== core/ddpi_core.sv ====
// DDR2 x16 pin interface: command sampling, power states, data path
`timescale 1ns/1ps
`include "ddpi_consts.svh"
module ddpi_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Clock pair and control pins
  input wire logic ck,
  input wire logic ck_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic odt,
  input wire logic org_x8,
  // Data pins
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe_n,
  // Strobe pins, bit 0 lower lane, bit 1 upper lane
  input wire logic [1:0] dqs_i,
  output logic [1:0] dqs_o,
  output logic [1:0] dqs_oe_n,
  input wire logic [1:0] dqs_n_i,
  output logic [1:0] dqs_n_o,
  output logic [1:0] dqs_n_oe_n,
  // Mask pins, lane 0 doubles as read strobe on x8
  input wire logic [1:0] dm_i,
  output logic [1:0] dm_o,
  output logic [1:0] dm_oe_n,
  // Status
  output logic clk_on,
  output logic odt_term,
  output logic [1:0] pwr_st,
  output logic [7:0] bank_open
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic ddpi_pkg::ddpi_cmd_e decode(
    input logic s_n, input logic r_n, input logic c_n, input logic w_n);
    ddpi_pkg::ddpi_cmd_e c;
    c = ddpi_pkg::CMD_NOP;
    if (!s_n) begin
      case ({r_n, c_n, w_n})
        3'h0: c = ddpi_pkg::CMD_MRS;
        3'h1: c = ddpi_pkg::CMD_REF;
        3'h2: c = ddpi_pkg::CMD_PRE;
        3'h3: c = ddpi_pkg::CMD_ACT;
        3'h4: c = ddpi_pkg::CMD_WR;
        3'h5: c = ddpi_pkg::CMD_RD;
        default: c = ddpi_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // Array is a small aliasing model: one bank bit, one row bit
  function automatic logic [4:0] mem_idx(
    input logic [2:0] bnk, input logic row0, input logic [2:0] col,
    input logic [2:0] beat, input logic long_bl);
    logic [2:0] c;
    c = long_bl ? col + beat : {col[2], col[1:0] + beat[1:0]};
    return {bnk[0], row0, c};
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic ck_s, ck_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s;
  logic odt_s, x8_s;
  logic [2:0] ba_s;
  logic [13:0] addr_s;
  logic [15:0] dq_s;
  logic [1:0] dqs_s, dqs_n_s, dm_s;
  logic [47:0] sync_q;

  ddpi_sync #(.W(48)) u_sync (
    .clk(ref_clk),
    .rst(sys_rst),
    .d({ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, org_x8,
        dq_i, dqs_i, dqs_n_i, dm_i}),
    .q(sync_q)
  );

  assign {ck_s, ck_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s,
          addr_s, odt_s, x8_s, dq_s, dqs_s, dqs_n_s, dm_s} = sync_q;

  // ---------------------------------------------------------------
  // Clock crossings and command
  // ---------------------------------------------------------------
  logic xhi_q, xlo_q, rise, fall, buf_on, odt_buf_on, cmd_v, long_bl;
  logic rtt_en, dqsn_dis, rdqs_on;
  ddpi_pkg::ddpi_cmd_e cmd_raw, cmd;
  ddpi_pkg::ddpi_pwr_e pwr_r;
  logic [13:0] mr_r, emr1_r, emr2_r, emr3_r;
  logic [3:0] bl_beats;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      xhi_q <= 1'b0;
      xlo_q <= 1'b0;
    end else begin
      xhi_q <= ck_s & ~ck_n_s;
      xlo_q <= ~ck_s & ck_n_s;
    end
  end

  assign rise = ck_s & ~ck_n_s & ~xhi_q;
  assign fall = ~ck_s & ck_n_s & ~xlo_q;
  assign buf_on = (pwr_r == ddpi_pkg::PWR_ACTIVE);
  assign odt_buf_on = (pwr_r != ddpi_pkg::PWR_SREF);
  assign cmd_raw = decode(cs_n_s, ras_n_s, cas_n_s, we_n_s);
  // Chip select high decodes as no-operation
  assign cmd_v = rise & buf_on & cke_s;
  assign cmd = cmd_v ? cmd_raw : ddpi_pkg::CMD_NOP;
  assign long_bl = (mr_r[`DDPI_BL_MSB:0] == `DDPI_BL8);
  assign bl_beats = long_bl ? `DDPI_BEATS_BL8 : `DDPI_BEATS_BL4;
  assign rtt_en = emr1_r[`DDPI_EMR1_RTT_LO] | emr1_r[`DDPI_EMR1_RTT_HI];
  assign dqsn_dis = emr1_r[`DDPI_EMR1_DQSN_DIS];
  assign rdqs_on = x8_s & emr1_r[`DDPI_EMR1_RDQS_EN];

  // ---------------------------------------------------------------
  // Mode registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mr_r <= `DDPI_RST_MODE;
      emr1_r <= `DDPI_RST_MODE;
      emr2_r <= `DDPI_RST_MODE;
      emr3_r <= `DDPI_RST_MODE;
    end else if (cmd == ddpi_pkg::CMD_MRS) begin
      if (ba_s == `DDPI_BA_MR) begin
        mr_r <= addr_s;
      end else if (ba_s == `DDPI_BA_EMR1) begin
        emr1_r <= addr_s;
      end else if (ba_s == `DDPI_BA_EMR2) begin
        emr2_r <= addr_s;
      end else if (ba_s == `DDPI_BA_EMR3) begin
        emr3_r <= addr_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // Banks and rows
  // ---------------------------------------------------------------
  logic [7:0] bank_open_r;
  logic [13:0] row_r [8];

  // Autoprecharge closes the bank at command time; no row timing kept
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bank_open_r <= 8'h00;
    end else if (cmd == ddpi_pkg::CMD_ACT) begin
      bank_open_r[ba_s] <= 1'b1;
    end else if (cmd == ddpi_pkg::CMD_PRE) begin
      if (addr_s[`DDPI_AP_BIT]) begin
        bank_open_r <= 8'h00;
      end else begin
        bank_open_r[ba_s] <= 1'b0;
      end
    end else if ((cmd == ddpi_pkg::CMD_RD || cmd == ddpi_pkg::CMD_WR) &&
                 addr_s[`DDPI_AP_BIT]) begin
      bank_open_r[ba_s] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (cmd == ddpi_pkg::CMD_ACT) begin
      row_r[ba_s] <= addr_s;
    end
  end

  // ---------------------------------------------------------------
  // Power states
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pwr_r <= ddpi_pkg::PWR_ACTIVE;
    end else begin
      case (pwr_r)
        ddpi_pkg::PWR_ACTIVE: begin
          if (rise && !cke_s) begin
            if (bank_open_r != 8'h00) begin
              pwr_r <= ddpi_pkg::PWR_APD;
            end else if (cmd_raw == ddpi_pkg::CMD_REF) begin
              pwr_r <= ddpi_pkg::PWR_SREF;
            end else begin
              pwr_r <= ddpi_pkg::PWR_PPD;
            end
          end
        end
        ddpi_pkg::PWR_PPD, ddpi_pkg::PWR_APD: begin
          if (rise && cke_s) begin
            pwr_r <= ddpi_pkg::PWR_ACTIVE;
          end
        end
        ddpi_pkg::PWR_SREF: begin
          // Clock pair may be stopped here, so no crossing is awaited
          if (cke_s) begin
            pwr_r <= ddpi_pkg::PWR_ACTIVE;
          end
        end
        default: pwr_r <= ddpi_pkg::PWR_ACTIVE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Write path
  // ---------------------------------------------------------------
  logic [15:0] mem_r [`DDPI_MEM_WORDS];
  logic [3:0] wleft_r [2];
  logic [2:0] wbeat_r [2];
  logic [2:0] wbank_r, wcol_r;
  logic wrow0_r;
  logic [1:0] stb, stb_q, sedge, dm_use, wen;
  logic [4:0] widx [2];

  always_comb begin
    for (int l = 0; l < 2; l++) begin
      stb[l] = dqsn_dis ? dqs_s[l] : dqs_s[l] & ~dqs_n_s[l];
      sedge[l] = buf_on & (stb[l] ^ stb_q[l]);
      dm_use[l] = dm_s[l] & ~((l == 0) & rdqs_on);
      wen[l] = sedge[l] & (wleft_r[l] != 4'h0) & ~dm_use[l];
      widx[l] = mem_idx(wbank_r, wrow0_r, wcol_r, wbeat_r[l], long_bl);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stb_q <= 2'h0;
    end else begin
      stb_q <= stb;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (cmd == ddpi_pkg::CMD_WR) begin
      wbank_r <= ba_s;
      wcol_r <= addr_s[2:0];
      wrow0_r <= row_r[ba_s][0];
    end
  end

  // Each lane follows its own strobe
  always_ff @(posedge ref_clk) begin
    for (int l = 0; l < 2; l++) begin
      if (sys_rst) begin
        wleft_r[l] <= 4'h0;
        wbeat_r[l] <= 3'h0;
      end else if (cmd == ddpi_pkg::CMD_WR) begin
        wleft_r[l] <= bl_beats;
        wbeat_r[l] <= 3'h0;
      end else if (sedge[l] && wleft_r[l] != 4'h0) begin
        wleft_r[l] <= wleft_r[l] - 4'h1;
        wbeat_r[l] <= wbeat_r[l] + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int l = 0; l < 2; l++) begin
      if (wen[l]) begin
        mem_r[widx[l]][8*l +: 8] <= dq_s[8*l +: 8];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [3:0] rleft_r;
  logic [2:0] rbeat_r, rbank_r, rcol_r;
  logic rrow0_r, f_in_ready, f_out_valid, f_out_ready, rd_on_r;
  logic [15:0] f_out_data;

  // Full FIFO stalls the array reader
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rleft_r <= 4'h0;
      rbeat_r <= 3'h0;
    end else if (cmd == ddpi_pkg::CMD_RD) begin
      rleft_r <= bl_beats;
      rbeat_r <= 3'h0;
    end else if (rleft_r != 4'h0 && f_in_ready) begin
      rleft_r <= rleft_r - 4'h1;
      rbeat_r <= rbeat_r + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (cmd == ddpi_pkg::CMD_RD) begin
      rbank_r <= ba_s;
      rcol_r <= addr_s[2:0];
      rrow0_r <= row_r[ba_s][0];
    end
  end

  // Burst only starts on a rising crossing, then takes every crossing
  assign f_out_ready = buf_on & (rise | (fall & rd_on_r));

  ddpi_fifo #(.W(16), .D(`DDPI_FIFO_DEPTH)) u_rdfifo (
    .clk(ref_clk),
    .rst(sys_rst),
    .in_valid(rleft_r != 4'h0),
    .in_ready(f_in_ready),
    .in_data(mem_r[mem_idx(rbank_r, rrow0_r, rcol_r, rbeat_r, long_bl)]),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // ---------------------------------------------------------------
  // Output drivers
  // ---------------------------------------------------------------
  logic drv_nxt, stb_nxt;
  logic [15:0] dq_o_r, dq_oe_n_r;
  logic [1:0] dqs_o_r, dqs_oe_n_r, dqs_n_o_r, dqs_n_oe_n_r, dm_o_r, dm_oe_n_r;
  logic odt_term_r, clk_on_r;

  // No latency or preamble modelled: data follows the crossing
  always_comb begin
    drv_nxt = rd_on_r;
    if (!buf_on) begin
      drv_nxt = 1'b0;
    end else if (rise || fall) begin
      drv_nxt = f_out_valid & f_out_ready;
    end
    stb_nxt = drv_nxt & rise;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_on_r <= 1'b0;
      dq_o_r <= 16'h0000;
      dq_oe_n_r <= 16'hFFFF;
      dqs_o_r <= 2'h0;
      dqs_oe_n_r <= 2'h3;
      dqs_n_o_r <= 2'h3;
      dqs_n_oe_n_r <= 2'h3;
      dm_o_r <= 2'h0;
      dm_oe_n_r <= 2'h3;
    end else begin
      rd_on_r <= drv_nxt;
      if (f_out_valid && f_out_ready) begin
        dq_o_r <= f_out_data;
      end
      dq_oe_n_r <= {16{~drv_nxt}};
      if (!drv_nxt || rise || fall) begin
        dqs_o_r <= {2{stb_nxt}};
        dqs_n_o_r <= {2{~stb_nxt}};
        dm_o_r <= {1'b0, stb_nxt};
      end
      dqs_oe_n_r <= {2{~drv_nxt}};
      dqs_n_oe_n_r <= {2{~drv_nxt | dqsn_dis}};
      dm_oe_n_r <= {1'b1, ~(drv_nxt & rdqs_on)};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      odt_term_r <= 1'b0;
    end else if (!odt_buf_on || !rtt_en) begin
      odt_term_r <= 1'b0;
    end else if (rise) begin
      odt_term_r <= odt_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clk_on_r <= 1'b1;
    end else begin
      clk_on_r <= buf_on;
    end
  end

  assign dq_o = dq_o_r;
  assign dq_oe_n = dq_oe_n_r;
  assign dqs_o = dqs_o_r;
  assign dqs_oe_n = dqs_oe_n_r;
  assign dqs_n_o = dqs_n_o_r;
  assign dqs_n_oe_n = dqs_n_oe_n_r;
  assign dm_o = dm_o_r;
  assign dm_oe_n = dm_oe_n_r;
  assign odt_term = odt_term_r;
  assign clk_on = clk_on_r;
  assign pwr_st = pwr_r;
  assign bank_open = bank_open_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  chk_cs_masks_cmd: assert property (
    rise && buf_on && cke_s && cs_n_s |=>
      $stable(bank_open_r) && $stable(mr_r) && $stable(emr1_r))
    else $error("command taken with chip select high");

  chk_act_opens_bank: assert property (
    cmd == ddpi_pkg::CMD_ACT |=> bank_open_r[$past(ba_s)])
    else $error("activate did not open the addressed bank");

  chk_pre_all_banks: assert property (
    cmd == ddpi_pkg::CMD_PRE && addr_s[`DDPI_AP_BIT] |=>
      bank_open_r == 8'h00)
    else $error("precharge all left a bank open");

  chk_mrs_opcode: assert property (
    cmd == ddpi_pkg::CMD_MRS && ba_s == `DDPI_BA_MR |=>
      mr_r == $past(addr_s))
    else $error("mode register not loaded from address");

  chk_sref_exit_async: assert property (
    pwr_r == ddpi_pkg::PWR_SREF && cke_s |=>
      pwr_r == ddpi_pkg::PWR_ACTIVE)
    else $error("self-refresh exit waited for a clock crossing");

  chk_apd_entry: assert property (
    pwr_r == ddpi_pkg::PWR_ACTIVE && rise && !cke_s &&
      bank_open_r != 8'h00 |=> pwr_r == ddpi_pkg::PWR_APD)
    else $error("open row did not give active power-down");

  chk_drivers_off: assert property (
    pwr_r != ddpi_pkg::PWR_ACTIVE |=> &dq_oe_n_r && &dqs_oe_n_r)
    else $error("drivers on while clock enable low");

  chk_odt_gate: assert property (
    !rtt_en |=> !odt_term_r)
    else $error("termination on while disabled by mode");

  chk_dqsn_off: assert property (
    dqsn_dis |=> &dqs_n_oe_n_r)
    else $error("complement strobe driven while disabled");

  chk_rd_strobe_edge: assert property (
    $rose(dqs_o_r[0]) |-> $past(rise) && !dq_oe_n_r[0])
    else $error("read strobe not aligned to crossing and data");
endmodule

// ==== sim/ddpi_ctrl_model.sv ====
// Controller model: clock pair, command pins and write bursts
`timescale 1ns/1ps
module ddpi_ctrl_model (
  // Design clock
  input wire logic ref_clk,
  // Clock pair and command pins
  output logic ck,
  output logic ck_n,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [13:0] addr,
  // Data, strobe and mask pins
  input wire logic [15:0] dq_o,
  input wire logic [15:0] dq_oe_n,
  output logic [15:0] dq_i,
  output logic [1:0] dqs_i,
  output logic [1:0] dqs_n_i,
  output logic [1:0] dm_i
);
  logic [15:0] m_dq = 16'h0000;
  logic m_drv = 1'b0;
  int n_div = 0;
  initial begin
    ck = 1'b0;
    ck_n = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 3'h0;
    addr = 14'h0000;
    dqs_i = 2'h0;
    dm_i = 2'h0;
  end
  // Pair runs free, 8 design cycles a period
  always @(negedge ref_clk) begin
    n_div <= (n_div + 1) % 4;
    if (n_div == 3) begin
      ck <= ~ck;
      ck_n <= ck;
    end
  end
  // Released data lines show the inverse, never a stale copy
  assign dq_i = (~dq_oe_n & dq_o) | (dq_oe_n & (m_drv ? m_dq : ~m_dq));
  assign dqs_n_i = ~dqs_i;
  task automatic cmd(input logic [2:0] rcw, input logic [2:0] b,
                     input logic [13:0] a, input logic sel_n);
    @(negedge ck);
    cs_n = sel_n;
    {ras_n, cas_n, we_n} = rcw;
    ba = b;
    addr = a;
    @(negedge ck);
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
  endtask
  // Strobe toggles mid-beat so data is stable both sides of it
  task automatic wr(input int n, input logic [15:0] base,
                    input logic [1:0] m1);
    cmd(3'h4, 3'h0, 14'h0000, 1'b0);
    m_drv = 1'b1;
    for (int i = 0; i < n; i++) begin
      m_dq = base + 16'(i) * 16'h0101;
      dm_i = (i == 1) ? m1 : 2'h0;
      repeat (2) @(negedge ref_clk);
      dqs_i = ~dqs_i;
      repeat (2) @(negedge ref_clk);
    end
    m_drv = 1'b0;
  endtask
endmodule

// ==== sim/test_ddr2_sdram_pin_interface.sv ====
// Testbench of the DDR2 pin interface against a controller model
`timescale 1ns/1ps
module test_ddr2_sdram_pin_interface;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cke = 1'b1;
  logic odt = 1'b0;
  logic org_x8 = 1'b0;
  logic ck, ck_n, cs_n, ras_n, cas_n, we_n, clk_on, odt_term;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [15:0] dq_i, dq_o, dq_oe_n;
  logic [1:0] dqs_i, dqs_o, dqs_oe_n, dqs_n_i, dqs_n_o, dqs_n_oe_n;
  logic [1:0] dm_i, dm_o, dm_oe_n, pwr_st;
  logic [7:0] bank_open;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  always #20 ref_clk = ~ref_clk;
  ddpi_core ddpi_core_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
    .org_x8(org_x8), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
    .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n),
    .dqs_n_i(dqs_n_i), .dqs_n_o(dqs_n_o), .dqs_n_oe_n(dqs_n_oe_n),
    .dm_i(dm_i), .dm_o(dm_o), .dm_oe_n(dm_oe_n), .clk_on(clk_on),
    .odt_term(odt_term), .pwr_st(pwr_st), .bank_open(bank_open));
  ddpi_ctrl_model ddpi_ctrl_model_inst (.ref_clk(ref_clk), .ck(ck),
    .ck_n(ck_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
    .dq_i(dq_i), .dqs_i(dqs_i), .dqs_n_i(dqs_n_i), .dm_i(dm_i));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cm(input logic [2:0] rcw, input logic [2:0] b,
                    input logic [13:0] a, input logic s);
    ddpi_ctrl_model_inst.cmd(rcw, b, a, s);
  endtask
  // Read burst; beats picked up at each strobe change while driving
  task automatic rd(input int n, input logic [15:0] base,
                    input logic [15:0] b1, input logic [1:0] nexp);
    logic [1:0] last;
    int i;
    logic ev;
    last = 2'h0;
    i = 0;
    cm(3'h5, 3'h0, 14'h0000, 1'b0);
    for (int k = 0; k < 120 && i < n; k++) begin
      @(negedge ref_clk);
      if (dq_oe_n === 16'h0000 && dqs_o !== last) begin
        chk(dq_o, (i == 1) ? b1 : base + 16'(i) * 16'h0101, "beat");
        chk(16'(dqs_o), (i % 2 == 0) ? 16'h3 : 16'h0, "strobe");
        chk(16'(dqs_n_oe_n), 16'(nexp), "complement");
        ev = (i % 2 == 0);
        chk(16'({dqs_oe_n, dqs_n_o}), ev ? 16'h0 : 16'h3, "drive");
        chk(16'(dm_oe_n), 16'({1'b1, ~org_x8}), "dm drive");
        chk(16'(dm_o), 16'(ev), "dm out");
        last = dqs_o;
        i++;
      end
    end
    chk(16'(i), 16'(n), "beat count");
    repeat (8) @(negedge ref_clk);
    chk(dq_oe_n, 16'hFFFF, "release");
  endtask
  task automatic t_banks;
    cm(3'h3, 3'h3, 14'h0005, 1'b0);
    chk(16'(bank_open), 16'h08, "activate");
    cm(3'h3, 3'h5, 14'h0000, 1'b1);
    chk(16'(bank_open), 16'h08, "deselected");
    cm(3'h6, 3'h5, 14'h0000, 1'b0);
    chk(16'(bank_open), 16'h08, "no-op code");
    cm(3'h3, 3'h6, 14'h0000, 1'b0);
    cm(3'h2, 3'h3, 14'h0000, 1'b0);
    chk(16'(bank_open), 16'h40, "one bank");
    cm(3'h3, 3'h1, 14'h0000, 1'b0);
    cm(3'h2, 3'h0, 14'h0400, 1'b0);
    chk(16'(bank_open), 16'h00, "all banks");
    $display("test banks done");
  endtask
  // Clock enable stays high through all bursts
  task automatic t_data;
    cm(3'h3, 3'h0, 14'h0000, 1'b0);
    ddpi_ctrl_model_inst.wr(4, 16'h1020, 2'h0);
    ddpi_ctrl_model_inst.wr(4, 16'h5060, 2'h1);
    rd(4, 16'h5060, 16'h5121, 2'h0);
    cm(3'h0, 3'h1, 14'h0400, 1'b0);
    cm(3'h0, 3'h0, 14'h0003, 1'b0);
    ddpi_ctrl_model_inst.wr(8, 16'h0A0B, 2'h0);
    rd(8, 16'h0A0B, 16'h0B0C, 2'h3);
    cm(3'h0, 3'h1, 14'h0000, 1'b0);
    cm(3'h0, 3'h0, 14'h0000, 1'b0);
    cm(3'h2, 3'h0, 14'h0400, 1'b0);
    $display("test data done");
  endtask
  // Lower mask pin turns into read strobe; write mask there is ignored
  task automatic t_rdqs;
    org_x8 = 1'b1;
    cm(3'h0, 3'h1, 14'h0800, 1'b0);
    cm(3'h3, 3'h0, 14'h0000, 1'b0);
    ddpi_ctrl_model_inst.wr(4, 16'h3040, 2'h1);
    rd(4, 16'h3040, 16'h3141, 2'h0);
    cm(3'h0, 3'h1, 14'h0000, 1'b0);
    cm(3'h2, 3'h0, 14'h0400, 1'b0);
    org_x8 = 1'b0;
    $display("test rdqs done");
  endtask
  task automatic t_odt;
    odt = 1'b1;
    cm(3'h0, 3'h1, 14'h0004, 1'b0);
    repeat (16) @(negedge ref_clk);
    chk(16'(odt_term), 16'h1, "term on");
    cm(3'h0, 3'h1, 14'h0000, 1'b0);
    repeat (4) @(negedge ref_clk);
    chk(16'(odt_term), 16'h0, "term off");
    odt = 1'b0;
    $display("test odt done");
  endtask
  task automatic t_power;
    cm(3'h3, 3'h2, 14'h0000, 1'b0);
    cke = 1'b0;
    repeat (20) @(negedge ref_clk);
    chk(16'(pwr_st), 16'h2, "active pd");
    chk(16'(clk_on), 16'h0, "clocks off");
    cm(3'h3, 3'h4, 14'h0000, 1'b0);
    cke = 1'b1;
    repeat (20) @(negedge ref_clk);
    chk(16'(pwr_st), 16'h0, "pd exit");
    chk(16'(bank_open), 16'h04, "ignored in pd");
    cm(3'h2, 3'h0, 14'h0400, 1'b0);
    fork
      cm(3'h1, 3'h0, 14'h0000, 1'b0);
      begin
        @(negedge ck);
        cke = 1'b0;
      end
    join
    repeat (20) @(negedge ref_clk);
    chk(16'(pwr_st), 16'h3, "self refresh");
    cke = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(16'(pwr_st), 16'h0, "sref exit");
    $display("test power done");
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(16'(bank_open), 16'h00, "reset banks");
    chk(16'(pwr_st), 16'h0, "reset power");
    chk(dq_oe_n, 16'hFFFF, "reset drivers");
    $display("test reset done");
    t_banks();
    t_data();
    t_rdqs();
    t_odt();
    t_power();
    stop_test();
  end
endmodule
